// >>> rtl/pbc_pkg.sv
package pbc_pkg;

  // ==========================================================
  // Register indices (host-side register port)
  localparam logic [3:0] ADDR_POWER_CONTROL     = 4'h0;
  localparam logic [3:0] ADDR_BACKUP_MEMORY_A   = 4'h1;
  localparam logic [3:0] ADDR_BACKUP_MEMORY_B   = 4'h2;
  localparam logic [3:0] ADDR_BACKUP_MEMORY_C   = 4'h3;
  localparam logic [3:0] ADDR_BACKUP_MEMORY_D   = 4'h4;
  localparam logic [3:0] ADDR_BUCK_ONE_NORMAL   = 4'h5;
  localparam logic [3:0] ADDR_BUCK_ONE_STANDBY  = 4'h6;
  localparam logic [3:0] ADDR_BUCK_ONE_SLEEP    = 4'h7;
  localparam logic [3:0] ADDR_BUCK_ONE_MODE     = 4'h8;
  localparam logic [3:0] ADDR_BUCK_ONE_CONFIG   = 4'h9;
  localparam int         BACKUP_BYTES           = 4;

  // ==========================================================
  // Implemented-bit masks (unassigned bits read zero)
  localparam logic [7:0] MASK_POWER_CONTROL = 8'hdf;
  localparam logic [7:0] MASK_VOLTAGE       = 8'h1f;
  localparam logic [7:0] MASK_MODE          = 8'h2f;
  localparam logic [7:0] MASK_CONFIG        = 8'h7d;

  // ==========================================================
  // Field positions
  localparam int POS_LDO_SHORT_PROTECT  = 7;
  localparam int POS_STANDBY_POLARITY   = 6;
  localparam int POS_STANDBY_DELAY_LO   = 3;
  localparam int POS_DEBOUNCE_LO        = 2;
  localparam int POS_LONG_LOW_OFF       = 1;
  localparam int POS_AUTO_RESTART       = 0;
  localparam int POS_OFF_MODE           = 5;
  localparam int POS_STEP_RATE          = 6;
  localparam int POS_PHASE_LO           = 4;
  localparam int POS_FREQ_LO            = 2;
  localparam int POS_CURRENT_LIMIT      = 0;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RESET_POWER_CONTROL = 8'h08;
  localparam logic [7:0] RESET_BACKUP        = 8'h00;

  // ==========================================================
  // Timing
  localparam int CLK_HZ             = 20_000_000;
  localparam int SLOW_HZ            = 32_768;
  localparam int SLOW_DIV           = CLK_HZ / SLOW_HZ;
  localparam int LONG_LOW_S         = 4;
  localparam int LONG_LOW_TICKS     = LONG_LOW_S * SLOW_HZ;
  localparam int STEP_FAST_NS       = 2000;
  localparam int STEP_SLOW_NS       = 4000;
  localparam int CLK_PERIOD_NS      = 50;
  localparam int STEP_FAST_CYC      = STEP_FAST_NS / CLK_PERIOD_NS;
  localparam int STEP_SLOW_CYC      = STEP_SLOW_NS / CLK_PERIOD_NS;
  localparam int DEBOUNCE_TICKS0    = 1;
  localparam int DEBOUNCE_TICKS1    = 8;
  localparam int DEBOUNCE_TICKS2    = 32;
  localparam int DEBOUNCE_TICKS3    = 128;

  // ==========================================================
  // Carried groups
  typedef struct packed {
    logic       write;
    logic       read;
    logic [3:0] addr;
    logic [7:0] wdata;
  } pbc_req_t;

  typedef struct packed {
    logic [7:0] normal_volt;
    logic [7:0] standby_volt;
    logic [7:0] sleep_volt;
    logic [7:0] mode;
    logic [7:0] config_reg;
  } pbc_otp_t;

endpackage

// >>> rtl/pbc_backup_mem.sv
`timescale 1ns/1ps
module pbc_backup_mem #(
  parameter int BYTES = pbc_pkg::BACKUP_BYTES
) (
  // Clock and coin-cell reset
  input  wire logic                 ref_clk,
  input  wire logic                 coin_rst_b,
  // Write port
  input  wire logic                 wr_en,
  input  wire logic [1:0]           wr_sel,
  input  wire logic [7:0]           wr_data,
  // Contents
  output logic      [BYTES*8-1:0]   mem_flat
);

  // ==========================================================
  // Byte storage
  // Only the coin-cell reset clears these; main reset never reaches them
  logic [7:0] mem_q [BYTES];

  genvar gi;
  generate
    for (gi = 0; gi < BYTES; gi++) begin : g_byte
      always_ff @(posedge ref_clk or negedge coin_rst_b) begin
        if (!coin_rst_b) begin
          mem_q[gi] <= pbc_pkg::RESET_BACKUP;
        end else if (wr_en && wr_sel == 2'(gi)) begin
          mem_q[gi] <= wr_data;
        end
      end
      assign mem_flat[gi*8 +: 8] = mem_q[gi];
    end
  endgenerate

endmodule

// >>> rtl/pbc_slow_tick.sv
`timescale 1ns/1ps
module pbc_slow_tick #(
  parameter int DIV = pbc_pkg::SLOW_DIV
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_b,
  // One-cycle pulse per 32 kHz period
  output logic      tick
);

  // ==========================================================
  // Divider; remainder of the integer divide is ignored
  logic [15:0] cnt_q;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b0;
    end else if (cnt_q == 16'(DIV - 1)) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      tick  <= 1'b0;
    end
  end

endmodule

// >>> rtl/pbc_regs.sv
`timescale 1ns/1ps
// Operation
// - Short-protect bit set: shut down any LDO reporting current limit.
// - Standby polarity bit: 0 pin active high, 1 pin active low.
// - Standby delay field: 0 to 3 slow-clock periods before standby entry.
// - Standby delay resets to code 01, one slow-clock period.
// - Debounce field selects filter time on the enable pin.
// - Long-low bit set: enable held low four seconds forces off mode.
// - Auto-restart plus power config: restart after long-low power-off.
// - Backup bytes survive main battery loss while coin cell present.
// - Backup bytes cleared only by coin-cell reset.
// - Five-bit normal voltage code for buck one.
// - Five-bit standby voltage code for buck one.
// - Five-bit sleep voltage code for buck one.
// - Buck registers load reset values from OTP configuration.
// - Off-mode bit picks off or sleep after buck turn-off.
// - Four-bit switching mode for buck one.
// - Step-rate bit: 25 mV per 2 us or per 4 us.
// - Two-bit phase select for buck one.
// - Two-bit frequency select for buck one.
// - Current-limit bit: 0 about 4 A, 1 about 2 A.
// - Every register readable and writable at any time; buck writes in the first cycle after reset are lost to the OTP load.
module pbc_regs #(
  parameter int LDO_COUNT      = 6,
  parameter int LONG_LOW_TICKS = pbc_pkg::LONG_LOW_TICKS
) (
  // Clock and resets
  input  wire logic                 ref_clk,
  input  wire logic                 rst_b,
  input  wire logic                 coin_rst_b,
  // Register port
  input  wire pbc_pkg::pbc_req_t    req,
  output logic      [7:0]           rdata_q,
  // OTP defaults
  input  wire pbc_pkg::pbc_otp_t    otp,
  // Pins and status
  input  wire logic                 standby_request_pin,
  input  wire logic                 enable_pin,
  input  wire logic                 power_config_select,
  input  wire logic [LDO_COUNT-1:0] ldo_current_limit,
  input  wire logic                 buck_one_turn_off,
  // Controls out
  output logic [LDO_COUNT-1:0]      ldo_shutdown_q,
  output logic                      standby_active_q,
  output logic                      enable_filtered_q,
  output logic                      off_mode_q,
  output logic                      restart_q,
  output logic [4:0]                buck_one_vset_q,
  output logic                      buck_one_sleep_q,
  output logic                      buck_one_off_q,
  output logic [3:0]                buck_one_mode_q,
  output logic                      buck_one_step_q,
  output logic [1:0]                buck_one_phase_q,
  output logic [1:0]                buck_one_freq_q,
  output logic                      buck_one_ilim_low_q
);

  // ==========================================================
  // Register storage
  logic [7:0] pwr_q;
  logic [7:0] volt_q;
  logic [7:0] standby_request_pin_q;
  logic [7:0] sleep_q;
  logic [7:0] mode_q;
  logic [7:0] conf_q;
  logic [31:0] mem_flat;
  logic        tick;
  logic        wr;

  assign wr = req.write;

  // Power control; only implemented bits stored
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pwr_q <= pbc_pkg::RESET_POWER_CONTROL;
    end else if (wr && req.addr == pbc_pkg::ADDR_POWER_CONTROL) begin
      pwr_q <= req.wdata & pbc_pkg::MASK_POWER_CONTROL;
    end
  end

  // Buck registers: OTP values captured one cycle after reset release,
  // since an async reset may only load constants
  logic otp_loaded_q;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      otp_loaded_q <= 1'b0;
    end else begin
      otp_loaded_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      volt_q  <= 8'h00;
      standby_request_pin_q  <= 8'h00;
      sleep_q <= 8'h00;
      mode_q  <= 8'h00;
      conf_q  <= 8'h00;
    end else if (!otp_loaded_q) begin
      volt_q  <= otp.normal_volt & pbc_pkg::MASK_VOLTAGE;
      standby_request_pin_q  <= otp.standby_volt & pbc_pkg::MASK_VOLTAGE;
      sleep_q <= otp.sleep_volt & pbc_pkg::MASK_VOLTAGE;
      mode_q  <= otp.mode & pbc_pkg::MASK_MODE;
      conf_q  <= otp.config_reg & pbc_pkg::MASK_CONFIG;
    end else if (wr) begin
      case (req.addr)
        pbc_pkg::ADDR_BUCK_ONE_NORMAL:  volt_q  <= req.wdata & pbc_pkg::MASK_VOLTAGE;
        pbc_pkg::ADDR_BUCK_ONE_STANDBY: standby_request_pin_q  <= req.wdata & pbc_pkg::MASK_VOLTAGE;
        pbc_pkg::ADDR_BUCK_ONE_SLEEP:   sleep_q <= req.wdata & pbc_pkg::MASK_VOLTAGE;
        pbc_pkg::ADDR_BUCK_ONE_MODE:    mode_q  <= req.wdata & pbc_pkg::MASK_MODE;
        pbc_pkg::ADDR_BUCK_ONE_CONFIG:  conf_q  <= req.wdata & pbc_pkg::MASK_CONFIG;
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Backup bytes on the coin-cell domain reset
  logic mem_wr;
  assign mem_wr = wr && req.addr >= pbc_pkg::ADDR_BACKUP_MEMORY_A
                     && req.addr <= pbc_pkg::ADDR_BACKUP_MEMORY_D;

  pbc_backup_mem #(
    .BYTES (pbc_pkg::BACKUP_BYTES)
  ) u_mem (
    .ref_clk    (ref_clk),
    .coin_rst_b (coin_rst_b),
    .wr_en      (mem_wr),
    .wr_sel     (2'(req.addr - pbc_pkg::ADDR_BACKUP_MEMORY_A)),
    .wr_data    (req.wdata),
    .mem_flat   (mem_flat)
  );

  // Read mux, registered; accepted in every state
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 8'h00;
    end else if (req.read) begin
      case (req.addr)
        pbc_pkg::ADDR_POWER_CONTROL:    rdata_q <= pwr_q;
        pbc_pkg::ADDR_BACKUP_MEMORY_A:  rdata_q <= mem_flat[7:0];
        pbc_pkg::ADDR_BACKUP_MEMORY_B:  rdata_q <= mem_flat[15:8];
        pbc_pkg::ADDR_BACKUP_MEMORY_C:  rdata_q <= mem_flat[23:16];
        pbc_pkg::ADDR_BACKUP_MEMORY_D:  rdata_q <= mem_flat[31:24];
        pbc_pkg::ADDR_BUCK_ONE_NORMAL:  rdata_q <= volt_q;
        pbc_pkg::ADDR_BUCK_ONE_STANDBY: rdata_q <= standby_request_pin_q;
        pbc_pkg::ADDR_BUCK_ONE_SLEEP:   rdata_q <= sleep_q;
        pbc_pkg::ADDR_BUCK_ONE_MODE:    rdata_q <= mode_q;
        pbc_pkg::ADDR_BUCK_ONE_CONFIG:  rdata_q <= conf_q;
        default:                        rdata_q <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Slow clock tick
  pbc_slow_tick #(
    .DIV (pbc_pkg::SLOW_DIV)
  ) u_tick (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .tick    (tick)
  );

  // ==========================================================
  // LDO short protection; latched until the bit is cleared
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ldo_shutdown_q <= '0;
    end else if (!pwr_q[pbc_pkg::POS_LDO_SHORT_PROTECT]) begin
      ldo_shutdown_q <= '0;
    end else begin
      ldo_shutdown_q <= ldo_shutdown_q | ldo_current_limit;
    end
  end

  // ==========================================================
  // Standby entry with polarity and delay
  logic       standby_request_pin_req;
  logic [1:0] standby_request_pin_cnt_q;
  assign standby_request_pin_req = standby_request_pin ^ pwr_q[pbc_pkg::POS_STANDBY_POLARITY];

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      standby_request_pin_cnt_q       <= 2'b00;
      standby_active_q <= 1'b0;
    end else if (!standby_request_pin_req) begin
      standby_request_pin_cnt_q       <= 2'b00;
      standby_active_q <= 1'b0;
    end else if (standby_request_pin_cnt_q == pwr_q[pbc_pkg::POS_STANDBY_DELAY_LO +: 2]) begin
      standby_active_q <= 1'b1;
    end else if (tick) begin
      standby_request_pin_cnt_q <= standby_request_pin_cnt_q + 2'b01;
    end
  end

  // ==========================================================
  // Enable pin debounce; field overlaps delay bits as laid out
  logic [1:0] dbnc_sel;
  logic [7:0] dbnc_lim;
  logic [7:0] dbnc_cnt_q;
  assign dbnc_sel = pwr_q[pbc_pkg::POS_DEBOUNCE_LO +: 2];

  always_comb begin
    case (dbnc_sel)
      2'b00:   dbnc_lim = 8'(pbc_pkg::DEBOUNCE_TICKS0);
      2'b01:   dbnc_lim = 8'(pbc_pkg::DEBOUNCE_TICKS1);
      2'b10:   dbnc_lim = 8'(pbc_pkg::DEBOUNCE_TICKS2);
      default: dbnc_lim = 8'(pbc_pkg::DEBOUNCE_TICKS3);
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dbnc_cnt_q        <= 8'h00;
      enable_filtered_q <= 1'b0;
    end else if (enable_pin == enable_filtered_q) begin
      dbnc_cnt_q <= 8'h00;
    end else if (dbnc_cnt_q >= dbnc_lim) begin
      enable_filtered_q <= enable_pin;
      dbnc_cnt_q        <= 8'h00;
    end else if (tick) begin
      dbnc_cnt_q <= dbnc_cnt_q + 8'h01;
    end
  end

  // ==========================================================
  // Long-low off and automatic restart
  logic [17:0] low_cnt_q;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      low_cnt_q  <= 18'h00000;
      off_mode_q <= 1'b0;
      restart_q  <= 1'b0;
    end else begin
      restart_q <= 1'b0;
      if (enable_filtered_q) begin
        low_cnt_q <= 18'h00000;
        off_mode_q <= 1'b0;
      end else if (low_cnt_q == 18'(LONG_LOW_TICKS)) begin
        if (pwr_q[pbc_pkg::POS_LONG_LOW_OFF] && !off_mode_q) begin
          off_mode_q <= 1'b1;
          restart_q  <= pwr_q[pbc_pkg::POS_AUTO_RESTART] & power_config_select;
        end
      end else if (tick) begin
        low_cnt_q <= low_cnt_q + 18'h00001;
      end
    end
  end

  // ==========================================================
  // Buck one control outputs
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      buck_one_vset_q     <= 5'h00;
      buck_one_sleep_q    <= 1'b0;
      buck_one_off_q      <= 1'b0;
      buck_one_mode_q     <= 4'h0;
      buck_one_step_q     <= 1'b0;
      buck_one_phase_q    <= 2'b00;
      buck_one_freq_q     <= 2'b00;
      buck_one_ilim_low_q <= 1'b0;
    end else begin
      if (buck_one_turn_off) begin
        buck_one_sleep_q <= mode_q[pbc_pkg::POS_OFF_MODE];
        buck_one_off_q   <= !mode_q[pbc_pkg::POS_OFF_MODE];
      end
      if (buck_one_turn_off ? mode_q[pbc_pkg::POS_OFF_MODE] : buck_one_sleep_q) begin
        buck_one_vset_q <= sleep_q[4:0];
      end else if (standby_active_q) begin
        buck_one_vset_q <= standby_request_pin_q[4:0];
      end else begin
        buck_one_vset_q <= volt_q[4:0];
      end
      buck_one_mode_q     <= mode_q[3:0];
      buck_one_step_q     <= conf_q[pbc_pkg::POS_STEP_RATE];
      buck_one_phase_q    <= conf_q[pbc_pkg::POS_PHASE_LO +: 2];
      buck_one_freq_q     <= conf_q[pbc_pkg::POS_FREQ_LO +: 2];
      buck_one_ilim_low_q <= conf_q[pbc_pkg::POS_CURRENT_LIMIT];
    end
  end

endmodule

// >>> bench/pbc_regs_checker.sv
`timescale 1ns/1ps
// ==========================================================
// Port-level checks on the register bank
module pbc_regs_checker #(
  parameter int LDO_COUNT      = 6,
  parameter int LONG_LOW_TICKS = pbc_pkg::LONG_LOW_TICKS
) (
  // Clock and reset
  input wire logic                 ref_clk,
  input wire logic                 rst_b,
  // Register port
  input wire pbc_pkg::pbc_req_t    req,
  input wire logic [7:0]           rdata_q,
  // Pins
  input wire logic                 standby_request_pin,
  input wire logic                 power_config_select,
  input wire logic [LDO_COUNT-1:0] ldo_current_limit,
  // Controls
  input wire logic [LDO_COUNT-1:0] ldo_shutdown_q,
  input wire logic                 standby_active_q,
  input wire logic                 enable_filtered_q,
  input wire logic                 off_mode_q,
  input wire logic                 restart_q,
  input wire logic [4:0]           buck_one_vset_q,
  input wire logic                 buck_one_sleep_q,
  input wire logic [3:0]           buck_one_mode_q,
  input wire logic                 buck_one_step_q,
  input wire logic [1:0]           buck_one_phase_q,
  input wire logic [1:0]           buck_one_freq_q,
  input wire logic                 buck_one_ilim_low_q
);
  localparam int DIV = pbc_pkg::SLOW_DIV;
  logic [7:0]  pc_q;
  logic [15:0] act_cnt_q;
  logic [15:0] low_cnt_q;
  logic        act;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Request level after the polarity bit
  assign act = standby_request_pin ^ pc_q[6];
  // Shadow of the power control byte, fed by host writes
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_q <= 8'h08;
    end else if (req.write && req.addr == pbc_pkg::ADDR_POWER_CONTROL) begin
      pc_q <= req.wdata & pbc_pkg::MASK_POWER_CONTROL;
    end
  end
  // Cycles the standby request has stood; saturates to avoid wrap
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      act_cnt_q <= 16'h0000;
    end else begin
      act_cnt_q <= !act ? 16'h0000 : act_cnt_q + {15'h0000, act_cnt_q != 16'hffff};
    end
  end
  // Cycles the filtered enable has been low
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      low_cnt_q <= 16'h0000;
    end else begin
      low_cnt_q <= enable_filtered_q ? 16'h0000
                 : low_cnt_q + {15'h0000, low_cnt_q != 16'hffff};
    end
  end
  a_pc_readback: assert property (req.read && !req.write && req.addr == 4'h0
    |=> rdata_q == $past(pc_q)) else $error("power control read mismatch");
  a_unmapped_zero: assert property (req.read && req.addr > 4'h9
    |=> rdata_q == 8'h00) else $error("unmapped read not zero");
  a_ldo_hold_off: assert property (!pc_q[7]
    |=> ldo_shutdown_q == '0) else $error("ldo shut with protect clear");
  a_ldo_trip: assert property (pc_q[7]
    |=> (ldo_shutdown_q & $past(ldo_current_limit)) == $past(ldo_current_limit))
    else $error("limited ldo not shut");
  a_standby_wait: assert property ($rose(standby_active_q)
    |-> act_cnt_q != 16'h0000 && act_cnt_q + DIV >= pc_q[4:3] * DIV)
    else $error("standby entered early");
  a_off_cause: assert property ($rose(off_mode_q)
    |-> pc_q[1] && low_cnt_q >= (LONG_LOW_TICKS - 1) * DIV)
    else $error("off mode without long low");
  a_off_within: assert property (pc_q[1] && low_cnt_q == (LONG_LOW_TICKS + 2) * DIV
    |-> off_mode_q) else $error("off mode late");
  a_restart_cause: assert property (restart_q
    |-> $past(pc_q[0]) && $past(power_config_select)) else $error("restart without enable");
  a_cfg_copy: assert property (req.write && req.addr == 4'h9 |-> ##2
    {buck_one_step_q, buck_one_phase_q, buck_one_freq_q, buck_one_ilim_low_q}
    == {$past(req.wdata[6:2], 2), $past(req.wdata[0], 2)}) else $error("config copy");
  a_mode_copy: assert property (req.write && req.addr == 4'h8
    |-> ##2 buck_one_mode_q == $past(req.wdata[3:0], 2)) else $error("mode copy");
  a_vset_normal: assert property (req.write && req.addr == 4'h5 && !standby_active_q
    && !buck_one_sleep_q |-> ##2 buck_one_vset_q == $past(req.wdata[4:0], 2))
    else $error("normal voltage code");
endmodule

bind pbc_regs pbc_regs_checker #(.LDO_COUNT(LDO_COUNT), .LONG_LOW_TICKS(LONG_LOW_TICKS))
  pbc_regs_checker_i (.ref_clk(ref_clk), .rst_b(rst_b), .req(req), .rdata_q(rdata_q),
  .standby_request_pin(standby_request_pin), .power_config_select(power_config_select),
  .ldo_current_limit(ldo_current_limit), .ldo_shutdown_q(ldo_shutdown_q),
  .standby_active_q(standby_active_q), .enable_filtered_q(enable_filtered_q),
  .off_mode_q(off_mode_q), .restart_q(restart_q), .buck_one_vset_q(buck_one_vset_q),
  .buck_one_sleep_q(buck_one_sleep_q), .buck_one_mode_q(buck_one_mode_q),
  .buck_one_step_q(buck_one_step_q), .buck_one_phase_q(buck_one_phase_q),
  .buck_one_freq_q(buck_one_freq_q), .buck_one_ilim_low_q(buck_one_ilim_low_q));

// >>> bench/pbc_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// Host side of the register port
module pbc_host_model (
  // Clock
  input  wire logic        ref_clk,
  // Register port
  input  wire logic [7:0]  rdata_q,
  output pbc_pkg::pbc_req_t req
);
  // Idle until the first access
  initial begin
    req = '0;
  end
  // One-cycle write strobe; data inverted once released
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    req.write = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge ref_clk);
    req.write = 1'b0;
    req.wdata = ~d;
  endtask
  // Read strobe, answer taken at the second falling edge after the read edge
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    req.read = 1'b1;
    req.addr = a;
    @(negedge ref_clk);
    req.read = 1'b0;
    req.addr = ~a;
    @(negedge ref_clk);
    d = rdata_q;
  endtask
endmodule

// >>> bench/test_power_ctl_buck_one_config_regs.sv
`timescale 1ns/1ps
module test_power_ctl_buck_one_config_regs;
  // ==========================================================
  // Signals
  localparam int DIV = pbc_pkg::SLOW_DIV;
  localparam int LL  = 4;
  logic              ref_clk, rst_b, coin_rst_b, standby_request_pin_pin, en_pin, pcfg, turn_off, pol;
  logic              standby_request_pin_act, en_filt, off_mode, restart, b_sleep, b_off, b_step, b_ilim;
  logic [5:0]        ldo_lim, ldo_shut;
  logic [4:0]        vset;
  logic [3:0]        b_mode;
  logic [1:0]        b_phase, b_freq;
  logic [7:0]        rdata;
  logic [7:0]        masks [11];
  logic [7:0]        otp_b [5];
  pbc_pkg::pbc_req_t req;
  int                error_cnt, samples_checked, cyc, n, d, restart_cnt;
  // ==========================================================
  // Device, host and clock
  pbc_regs #(.LONG_LOW_TICKS(LL)) pbc_regs_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .coin_rst_b(coin_rst_b), .req(req), .rdata_q(rdata), .otp({otp_b[0], otp_b[1],
    otp_b[2], otp_b[3], otp_b[4]}), .standby_request_pin(standby_request_pin_pin), .enable_pin(en_pin),
    .power_config_select(pcfg), .ldo_current_limit(ldo_lim), .buck_one_turn_off(turn_off),
    .ldo_shutdown_q(ldo_shut), .standby_active_q(standby_request_pin_act), .enable_filtered_q(en_filt),
    .off_mode_q(off_mode), .restart_q(restart), .buck_one_vset_q(vset),
    .buck_one_sleep_q(b_sleep), .buck_one_off_q(b_off), .buck_one_mode_q(b_mode),
    .buck_one_step_q(b_step), .buck_one_phase_q(b_phase), .buck_one_freq_q(b_freq),
    .buck_one_ilim_low_q(b_ilim));
  pbc_host_model pbc_host_model_i (.ref_clk(ref_clk), .rdata_q(rdata), .req(req));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // Restart pulses are one cycle wide, so count them on every edge
  always @(posedge ref_clk) begin
    cyc++;
    if (restart === 1'b1) restart_cnt++;
    if (cyc == 70000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  // ==========================================================
  // Tasks
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] v;
    pbc_host_model_i.rd(a, v);
    chk(v, e);
  endtask
  task automatic cyc_wait(input int k);
    repeat (k) @(negedge ref_clk);
  endtask
  // Main reset only; requests wait for the second edge after release
  task automatic main_reset();
    @(negedge ref_clk);
    rst_b = 1'b0;
    cyc_wait(2);
    rst_b = 1'b1;
    cyc_wait(2);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Sequence
  initial begin
    {rst_b, coin_rst_b, standby_request_pin_pin, pcfg, turn_off, cyc, restart_cnt} = '0;
    {error_cnt, samples_checked, ldo_lim, en_pin} = 1;
    error_cnt = 0;
    otp_b = '{8'hf3, 8'he6, 8'hc9, 8'hf5, 8'hff};
    masks = '{8'hdf, 8'hff, 8'hff, 8'hff, 8'hff, 8'h1f, 8'h1f, 8'h1f, 8'h2f, 8'h7d, 8'h00};
    cyc_wait(2);
    {rst_b, coin_rst_b} = 2'b11;
    cyc_wait(2);
    rd_chk(4'h0, 8'h08);
    for (int i = 0; i < 5; i++) rd_chk(4'(5 + i), otp_b[i] & masks[5 + i]);
    for (int p = 0; p < 2; p++) begin
      for (int a = 0; a < 11; a++) begin
        pbc_host_model_i.wr(4'(a), p == 0 ? 8'hff : 8'ha5);
        rd_chk(4'(a), (p == 0 ? 8'hff : 8'ha5) & masks[a]);
      end
    end
    main_reset();
    for (int a = 1; a < 5; a++) rd_chk(4'(a), 8'ha5);
    coin_rst_b = 1'b0;
    cyc_wait(1);
    coin_rst_b = 1'b1;
    for (int a = 1; a < 5; a++) rd_chk(4'(a), 8'h00);
    // Shutdown latches while protection is on, clears when it is off
    ldo_lim = 6'h04;
    cyc_wait(3);
    chk({2'b00, ldo_shut}, 8'h00);
    pbc_host_model_i.wr(4'h0, 8'h80);
    cyc_wait(2);
    ldo_lim = 6'h00;
    cyc_wait(2);
    chk({2'b00, ldo_shut}, 8'h04);
    pbc_host_model_i.wr(4'h0, 8'h00);
    cyc_wait(2);
    chk({2'b00, ldo_shut}, 8'h00);
    // Each polarity with every delay; longest delay first hides the switch
    for (int i = 0; i < 8; i++) begin
      pol = 1'(i / 4);
      d = 3 - i % 4;
      pbc_host_model_i.wr(4'h0, {1'b0, pol, 1'b0, 2'(d), 3'b000});
      standby_request_pin_pin = pol;
      cyc_wait(4);
      chk({7'h00, standby_request_pin_act}, 8'h00);
      standby_request_pin_pin = ~pol;
      n = 0;
      while (standby_request_pin_act !== 1'b1 && n < 4 * DIV) begin
        cyc_wait(1);
        n++;
      end
      chk({7'h00, n >= (d - 1) * DIV && n <= d * DIV + 4}, 8'h01);
      // Voltage select follows the standby flag one edge later
      cyc_wait(1);
      chk({3'h0, vset}, otp_b[1] & 8'h1f);
      standby_request_pin_pin = pol;
      cyc_wait(2 * DIV);
    end
    // Debounce: short glitch filtered at code 1, long low passes at code 0
    pbc_host_model_i.wr(4'h0, 8'h00);
    cyc_wait(3 * DIV);
    chk({7'h00, en_filt}, 8'h01);
    pbc_host_model_i.wr(4'h0, 8'h04);
    en_pin = 1'b0;
    cyc_wait(2 * DIV);
    en_pin = 1'b1;
    cyc_wait(DIV);
    chk({7'h00, en_filt}, 8'h01);
    pbc_host_model_i.wr(4'h0, 8'h00);
    en_pin = 1'b0;
    cyc_wait(3 * DIV);
    chk({7'h00, en_filt}, 8'h00);
    cyc_wait((LL + 3) * DIV);
    chk({7'h00, off_mode}, 8'h00);
    en_pin = 1'b1;
    cyc_wait(3 * DIV);
    pcfg = 1'b1;
    pbc_host_model_i.wr(4'h0, 8'h03);
    en_pin = 1'b0;
    n = 0;
    while (off_mode !== 1'b1 && n < (LL + 4) * DIV) begin
      cyc_wait(1);
      n++;
    end
    // Stay low long enough for the checker's late-entry bound to be reached
    cyc_wait(4 * DIV);
    chk({7'h00, n < (LL + 4) * DIV}, 8'h01);
    chk(8'(restart_cnt), 8'h01);
    // Buck one fields, then turn-off into sleep and into off
    en_pin = 1'b1;
    pcfg = 1'b0;
    main_reset();
    chk({3'h0, vset}, otp_b[0] & 8'h1f);
    pbc_host_model_i.wr(4'h9, 8'h55);
    cyc_wait(1);
    chk({1'b0, b_step, b_phase, b_freq, 1'b0, b_ilim}, 8'h55);
    pbc_host_model_i.wr(4'h8, 8'h2a);
    turn_off = 1'b1;
    cyc_wait(1);
    turn_off = 1'b0;
    cyc_wait(3);
    chk({4'h0, b_mode}, 8'h0a);
    chk({b_sleep, b_off, 1'b0, vset}, {3'b100, otp_b[2][4:0]});
    main_reset();
    pbc_host_model_i.wr(4'h8, 8'h00);
    turn_off = 1'b1;
    cyc_wait(1);
    turn_off = 1'b0;
    cyc_wait(3);
    chk({b_sleep, b_off, 6'h00}, 8'h40);
    tally_and_finish();
  end
endmodule
